// *** rtl/tiop_top.sv ***
// timed i/o port block: five ports, six clock blocks, wishbone slave
//
// The address map and the Wishbone register port are this design's own decisions.
module tiop_top
    import tiop_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic pin_pd,
    input wire logic [NPORT-1:0] strobe_in,
    output logic [NPORT-1:0] strobe_out,
    output logic [NPORT-1:0] port_event
);

    localparam int SYNC_W = NPIN + NPORT;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic ack_reg;
    logic ack_next;
    logic [DAT_W-1:0] rdat_reg;
    logic [DAT_W-1:0] rdat_next;
    logic link_en_reg;
    logic link_en_next;
    logic pd_reg;
    logic pd_next;
    logic req;
    logic wr_en;
    logic rd_en;
    logic [2:0] region;
    logic [4:0] off;
    logic [DAT_W-1:0] wmask;

    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_en = req & wb_we_i;
    assign rd_en = req & ~wb_we_i;
    assign region = wb_adr_i[ADR_W-1:REGION_LSB];
    assign off = wb_adr_i[REGION_LSB-1:0];
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ****************************************************************
    // pin input synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [SYNC_W-1:0] filt_next;
    logic clk_pin_prev_reg;
    logic [NPIN-1:0] pins_f;
    logic [NPORT-1:0] strb_f;
    logic clk_pin_edge;

    // a change is taken only once the second and third stages agree
    always_comb begin
        filt_next = (~(s2_reg ^ s3_reg) & s3_reg)
                  | ((s2_reg ^ s3_reg) & filt_reg);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
            clk_pin_prev_reg <= 1'b0;
        end else begin
            s1_reg <= {strobe_in, pin_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
            clk_pin_prev_reg <= filt_reg[CLK_PIN];
        end
    end

    assign pins_f = filt_reg[NPIN-1:0];
    assign strb_f = filt_reg[SYNC_W-1:NPIN];
    assign clk_pin_edge = filt_reg[CLK_PIN] & ~clk_pin_prev_reg;

    // ****************************************************************
    // clock blocks
    // ****************************************************************
    tiop_clkb_t clkb_reg [NCLKB];
    logic [DIV_W-1:0] div_reg [NCLKB];
    logic [(1<<SEL_W)-1:0] clk_tick;

    // block zero ticks on every reference edge and cannot be changed
    assign clkb_reg[0] = CLKB_RST;
    assign div_reg[0] = '0;
    assign clk_tick[0] = 1'b1;
    assign clk_tick[(1<<SEL_W)-1:NCLKB] = '0;

    for (genvar k = 1; k < NCLKB; k++) begin : g_clkb
        tiop_clkb_t cfg_next;
        logic [DIV_W-1:0] cnt_next;
        logic tick_reg;
        logic tick_next;
        logic src_evt;

        always_comb begin
            cfg_next = clkb_reg[k];
            cnt_next = div_reg[k];
            tick_next = 1'b0;
            // source is the reference or the 1-bit port pin
            src_evt = clkb_reg[k].src_pin ? clk_pin_edge : 1'b1;
            if (src_evt) begin
                if (div_reg[k] >= clkb_reg[k].divide) begin
                    cnt_next = '0;
                    tick_next = 1'b1;
                end else begin
                    cnt_next = div_reg[k] + 1'b1;
                end
            end
            if (wr_en && region == CLKB_REGION
                    && wb_adr_i[REGION_LSB-1:CLKB_IDX_LSB] == 3'(k)) begin
                cfg_next = (clkb_reg[k] & wmask[CLKB_W-1:0])
                         ^ clkb_reg[k] | (wb_dat_i[CLKB_W-1:0]
                         & wmask[CLKB_W-1:0]);
                cnt_next = '0;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                clkb_reg[k] <= CLKB_RST;
                div_reg[k] <= '0;
                tick_reg <= 1'b0;
            end else begin
                clkb_reg[k] <= cfg_next;
                div_reg[k] <= cnt_next;
                tick_reg <= tick_next;
            end
        end

        assign clk_tick[k] = tick_reg;
    end

    // ****************************************************************
    // ports
    // ****************************************************************
    tiop_ctrl_t ctrl_reg [NPORT];
    logic [DAT_W-1:0] tx_reg [NPORT];
    logic [DAT_W-1:0] rx_reg [NPORT];
    logic [DAT_W-1:0] shift_reg [NPORT];
    logic [DAT_W-1:0] cond_reg [NPORT];
    logic [CNT_W-1:0] cnt_reg [NPORT];
    logic [CNT_W-1:0] time_reg [NPORT];
    logic [CNT_W-1:0] tstamp_reg [NPORT];
    tiop_stat_t stat_reg [NPORT];
    logic [NPORT-1:0] strb_reg;
    logic [NPORT-1:0] evt_reg;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        localparam int W = PORT_WIDTH[p];
        localparam logic [DAT_W-1:0] PMASK = (W == DAT_W) ? '1
            : DAT_W'((64'h1 << W) - 64'h1);
        tiop_ctrl_t ctrl_next;
        logic [DAT_W-1:0] tx_next;
        logic [DAT_W-1:0] rx_next;
        logic [DAT_W-1:0] shift_next;
        logic [DAT_W-1:0] cond_next;
        logic [CNT_W-1:0] cnt_next;
        logic [CNT_W-1:0] time_next;
        logic [CNT_W-1:0] tstamp_next;
        tiop_stat_t stat_next;
        logic armed_reg;
        logic armed_next;
        logic strb_next;
        logic hit;
        logic tk;
        logic time_ok;
        logic cond_ok;
        logic xfer;
        logic [DAT_W-1:0] sample;
        logic [DAT_W-1:0] wdat;

        always_comb begin
            hit = (region == 3'(p));
            tk = clk_tick[ctrl_reg[p].clk_sel];
            // full width is sampled even where pins are lent away
            sample = pins_f & PMASK;
            wdat = wb_dat_i & wmask;
            time_ok = ~armed_reg | (cnt_reg[p] == time_reg[p]);
            case (ctrl_reg[p].cond)
                COND_EQ: cond_ok = (sample == cond_reg[p]);
                COND_NEQ: cond_ok = (sample != cond_reg[p]);
                default: cond_ok = 1'b1;
            endcase
            xfer = ctrl_reg[p].enable & tk & time_ok
                 & (ctrl_reg[p].dir_out ? stat_reg[p].tx_full
                   : (cond_ok & (~ctrl_reg[p].strb_in_en
                   | strb_f[p])));
            ctrl_next = ctrl_reg[p];
            tx_next = tx_reg[p];
            rx_next = rx_reg[p];
            shift_next = shift_reg[p];
            cond_next = cond_reg[p];
            cnt_next = cnt_reg[p];
            time_next = time_reg[p];
            tstamp_next = tstamp_reg[p];
            stat_next = stat_reg[p];
            armed_next = armed_reg;
            strb_next = tk ? 1'b0 : strb_reg[p];
            if (ctrl_reg[p].enable & tk) begin
                cnt_next = cnt_reg[p] + 1'b1;
                if (!ctrl_reg[p].dir_out) begin
                    shift_next = sample;
                end
            end
            if (xfer) begin
                tstamp_next = cnt_reg[p];
                armed_next = 1'b0;
                if (ctrl_reg[p].dir_out) begin
                    shift_next = tx_reg[p];
                    stat_next.tx_full = 1'b0;
                    strb_next = ctrl_reg[p].strb_out_en;
                end else begin
                    rx_next = sample;
                end
            end
            if (hit && rd_en && off == OFF_DATA) begin
                stat_next.rx_full = 1'b0;
            end
            // a capture in the read cycle keeps the flag set
            if (xfer && !ctrl_reg[p].dir_out) begin
                stat_next.rx_full = 1'b1;
            end
            if (hit && wr_en) begin
                case (off)
                    OFF_CTRL: ctrl_next = (ctrl_reg[p]
                        & ~wmask[CTRL_W-1:0]) | wdat[CTRL_W-1:0];
                    OFF_DATA: begin
                        tx_next = ((tx_reg[p] & ~wmask) | wdat) & PMASK;
                        stat_next.tx_full = 1'b1;
                    end
                    OFF_COND: cond_next = ((cond_reg[p] & ~wmask)
                        | wdat) & PMASK;
                    OFF_TIME: begin
                        time_next = (time_reg[p] & ~wmask[CNT_W-1:0])
                            | wdat[CNT_W-1:0];
                        armed_next = 1'b1;
                    end
                    default: ;
                endcase
            end
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                ctrl_reg[p] <= CTRL_RST;
                tx_reg[p] <= '0;
                rx_reg[p] <= '0;
                shift_reg[p] <= '0;
                cond_reg[p] <= '0;
                cnt_reg[p] <= '0;
                time_reg[p] <= '0;
                tstamp_reg[p] <= '0;
                stat_reg[p] <= '0;
                armed_reg <= 1'b0;
                strb_reg[p] <= 1'b0;
                evt_reg[p] <= 1'b0;
            end else begin
                ctrl_reg[p] <= ctrl_next;
                tx_reg[p] <= tx_next;
                rx_reg[p] <= rx_next;
                shift_reg[p] <= shift_next;
                cond_reg[p] <= cond_next;
                cnt_reg[p] <= cnt_next;
                time_reg[p] <= time_next;
                tstamp_reg[p] <= tstamp_next;
                stat_reg[p] <= stat_next;
                armed_reg <= armed_next;
                strb_reg[p] <= strb_next;
                // event straight to the scheduler, no interrupt path
                evt_reg[p] <= xfer;
            end
        end
    end

    // ****************************************************************
    // pin ownership and drivers
    // ****************************************************************
    logic [NPIN-1:0] pout_reg;
    logic [NPIN-1:0] pout_next;
    logic [NPIN-1:0] poe_reg;
    logic [NPIN-1:0] poe_next;

    always_comb begin
        int own;
        logic found;
        logic dbit;
        own = 0;
        found = 1'b0;
        dbit = 1'b0;
        pout_next = '0;
        poe_next = '0;
        for (int i = 0; i < NPIN; i++) begin
            own = 0;
            found = 1'b0;
            // widest first, so the narrowest enabled owner wins
            for (int p = NPORT - 1; p >= 0; p--) begin
                if (ctrl_reg[p].enable && i < PORT_WIDTH[p]) begin
                    own = p;
                    found = 1'b1;
                end
            end
            if (link_en_reg && LINK_PINS[i]) begin
                found = 1'b0;
            end
            dbit = shift_reg[own][i];
            if (found && ctrl_reg[own].dir_out) begin
                if (ctrl_reg[own].open_coll) begin
                    pout_next[i] = 1'b0;
                    poe_next[i] = ~dbit;
                end else begin
                    pout_next[i] = dbit;
                    poe_next[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pout_reg <= '0;
            poe_reg <= '0;
        end else begin
            pout_reg <= pout_next;
            poe_reg <= poe_next;
        end
    end

    // ****************************************************************
    // bus answer and global state
    // ****************************************************************
    always_comb begin
        ack_next = req;
        link_en_next = link_en_reg;
        pd_next = 1'b0;
        rdat_next = '0;
        if (wr_en && region == LINK_REGION && off == OFF_LINK
                && wb_sel_i[0]) begin
            link_en_next = wb_dat_i[0];
        end
        if (rd_en) begin
            if (region < 3'(NPORT)) begin
                case (off)
                    OFF_CTRL: rdat_next = DAT_W'(ctrl_reg[region]);
                    OFF_DATA: rdat_next = rx_reg[region];
                    OFF_COND: rdat_next = cond_reg[region];
                    OFF_TIME: rdat_next = DAT_W'(cnt_reg[region]);
                    OFF_TSTAMP: rdat_next = DAT_W'(tstamp_reg[region]);
                    OFF_STAT: rdat_next = DAT_W'(stat_reg[region]);
                    default: rdat_next = '0;
                endcase
            end else if (region == CLKB_REGION) begin
                if (wb_adr_i[REGION_LSB-1:CLKB_IDX_LSB] < 3'(NCLKB)) begin
                    rdat_next = DAT_W'(clkb_reg[
                        wb_adr_i[REGION_LSB-1:CLKB_IDX_LSB]]);
                end
            end else if (region == LINK_REGION && off == OFF_LINK) begin
                rdat_next = DAT_W'(link_en_reg);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            link_en_reg <= 1'b0;
            pd_reg <= 1'b1;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            link_en_reg <= link_en_next;
            pd_reg <= pd_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign pin_out = pout_reg;
    assign pin_oe = poe_reg;
    assign pin_pd = pd_reg;
    assign strobe_out = strb_reg;
    assign port_event = evt_reg;

endmodule // tiop_top

// *** rtl/tiop_pkg.sv ***
// package: constants, field layouts and types of the timed i/o port block
package tiop_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NPORT = 5;
    localparam int NCLKB = 6;
    localparam int NPIN = 32;
    localparam int CNT_W = 16;
    localparam int DAT_W = 32;
    localparam int ADR_W = 8;
    localparam int DIV_W = 8;
    localparam int SEL_W = 3;
    localparam int PORT_WIDTH [NPORT] = '{1, 4, 8, 16, 32};
    // the 1-bit port's pin, usable as a clock block source
    localparam int CLK_PIN = 0;
    // pins shared with the inter-chip serial link
    localparam logic [NPIN-1:0] LINK_PINS = 32'hff00_0000;

    // ****************************************************************
    // register map: byte address = region * 0x20 + offset
    // ****************************************************************
    localparam int REGION_LSB = 5;
    localparam int CLKB_IDX_LSB = 2;
    localparam logic [2:0] CLKB_REGION = 3'h6;
    localparam logic [2:0] LINK_REGION = 3'h7;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_DATA = 5'h04;
    localparam logic [4:0] OFF_COND = 5'h08;
    localparam logic [4:0] OFF_TIME = 5'h0c;
    localparam logic [4:0] OFF_TSTAMP = 5'h10;
    localparam logic [4:0] OFF_STAT = 5'h14;
    localparam logic [4:0] OFF_LINK = 5'h00;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        COND_NONE,
        COND_EQ,
        COND_NEQ
    } tiop_cond_t;

    typedef struct packed {
        logic [SEL_W-1:0] clk_sel;
        tiop_cond_t cond;
        logic strb_out_en;
        logic strb_in_en;
        logic open_coll;
        logic dir_out;
        logic enable;
    } tiop_ctrl_t;

    typedef struct packed {
        logic src_pin;
        logic [DIV_W-1:0] divide;
    } tiop_clkb_t;

    typedef struct packed {
        logic tx_full;
        logic rx_full;
    } tiop_stat_t;

    localparam int CTRL_W = $bits(tiop_ctrl_t);
    localparam int CLKB_W = $bits(tiop_clkb_t);
    localparam int STAT_W = $bits(tiop_stat_t);
    localparam tiop_ctrl_t CTRL_RST = '0;
    localparam tiop_clkb_t CLKB_RST = '0;

endpackage

// *** verif/tiop_props.sv ***
// checker: bus, reset and link pin properties of the timed i/o port block
module tiop_props
    import tiop_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    input wire logic [DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic pin_pd,
    input wire logic [NPORT-1:0] strobe_out,
    input wire logic [NPORT-1:0] port_event
);
    logic link_reg;
    logic link_next;
    logic wr_link;

    // *****************************
    // link enable shadow
    // *****************************
    // taken at the request edge, as the slave takes it
    assign wr_link = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_sel_i[0] && wb_adr_i == {LINK_REGION, OFF_LINK};
    always_comb begin
        link_next = wr_link ? wb_dat_i[0] : link_reg;
    end
    always_ff @(posedge sys_clk) begin
        link_reg <= sys_rst ? 1'b0 : link_next;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
    a_pd_reset: assert property (
        disable iff (1'b0) sys_rst |=> pin_pd)
        else $error("no pull-down in reset");
    a_pd_run: assert property (
        disable iff (1'b0) !sys_rst |=> !pin_pd)
        else $error("pull-down outside reset");
    a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=>
        pin_oe == '0 && strobe_out == '0 && port_event == '0)
        else $error("outputs active in reset");
    a_link_off: assert property (
        link_reg [*3] |-> (pin_oe & LINK_PINS) == '0)
        else $error("link pins still driven");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_link: cover property (link_reg);
    c_event: cover property (|port_event);
endmodule // tiop_props

bind tiop_top tiop_props u_tiop_props (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_oe(pin_oe), .pin_pd(pin_pd), .strobe_out(strobe_out),
    .port_event(port_event));

// *** verif/tiop_pins.sv ***
// partner model: external hardware on the port pins
module tiop_pins
    import tiop_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic pin_pd,
    input wire logic [NPIN-1:0] drv_val,
    input wire logic [NPIN-1:0] drv_oe,
    input wire logic [NPORT-1:0] strb_req,
    output logic [NPIN-1:0] pin_in,
    output logic [NPORT-1:0] strobe_in
);
    logic [NPIN-1:0] float_reg = '0;
    logic [NPIN-1:0] float_next;

    // an undriven line toggles each cycle, which the input filter never takes, so the last settled level still reads as data
    always_comb begin
        float_next = ~float_reg;
    end
    // plain always: the start value comes from the declaration
    always @(posedge sys_clk) begin
        float_reg <= float_next;
    end
    // device drive wins; pin 0 may carry an outside clock
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & drv_oe & drv_val)
            | (~pin_oe & ~drv_oe & ~{NPIN{pin_pd}} & float_reg);
        strobe_in = strb_req;
    end
endmodule // tiop_pins

// *** verif/timed_io_port_clock_blocks_bench.sv ***
// testbench of the timed i/o port block
module timed_io_port_clock_blocks_bench
    import tiop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] wdat;
        logic [31:0] exp;
    } tiop_row_t;
    localparam tiop_row_t ROWS [8] = '{'{1'b0, 8'h00, 32'h0, 32'h0},
        '{1'b0, 8'h80, 32'h0, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0},
        '{1'b1, 8'hf0, 32'hffff_ffff, 32'h0},
        '{1'b1, 8'hc0, 32'h1ff, 32'h0}, '{1'b1, 8'hd4, 32'h1ff, 32'h1ff},
        '{1'b1, 8'h60, 32'h280, 32'h280}, '{1'b0, 8'he0, 32'h0, 32'h0}};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q, t1, t2;
    logic [3:0] wb_sel_i = 4'hf;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic [31:0] pin_in, pin_out, pin_oe, drv_val = '0, drv_oe = '0;
    logic [4:0] strobe_in, strobe_out, port_event, strb_req = '0;
    logic pin_pd, seen_evt = 1'b0, seen_strb = 1'b0;
    int err_count = 0;
    int checks = 0;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (port_event[0] === 1'b1) seen_evt <= 1'b1;
    always @(posedge sys_clk) if (strobe_out[1] === 1'b1) seen_strb <= 1'b1;

    tiop_top u_tiop_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd(pin_pd),
        .strobe_in(strobe_in), .strobe_out(strobe_out),
        .port_event(port_event));
    tiop_pins u_tiop_pins (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pd(pin_pd), .drv_val(drv_val),
        .drv_oe(drv_oe), .strb_req(strb_req), .pin_in(pin_in),
        .strobe_in(strobe_in));

    // *****************************
    // tasks
    // *****************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        r = wb_dat_o;
        cmp(32'(wb_ack_o), 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask
    task automatic end_sim;
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // *****************************
    // sequence
    // *****************************
    initial begin
        tick(6);
        cmp(32'(pin_pd), 32'h1);
        cmp(pin_oe, 32'h0);
        sys_rst <= 1'b0;
        tick(2);
        cmp(32'(pin_pd), 32'h0);
        foreach (ROWS[i]) begin
            if (ROWS[i].we) wr(ROWS[i].adr, ROWS[i].wdat);
            rd(ROWS[i].adr, q);
            cmp(q, ROWS[i].exp);
        end
        // input on port 0 gated by strobe and equal condition
        drv_oe <= 32'h1;
        drv_val <= 32'h1;
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h29);
        tick(12);
        rd(8'h14, q);
        cmp(q, 32'h0);
        strb_req <= 5'h1;
        tick(12);
        rd(8'h14, q);
        cmp(q, 32'h1);
        rd(8'h04, q);
        cmp(q, 32'h1);
        cmp(32'(seen_evt), 32'h1);
        strb_req <= 5'h0;
        // not-equal condition: no capture while the pin equals it
        wr(8'h00, 32'h41);
        rd(8'h04, q);
        tick(8);
        rd(8'h14, q);
        cmp(q, 32'h0);
        drv_val <= 32'h0;
        tick(8);
        rd(8'h14, q);
        cmp(q, 32'h1);
        wr(8'h00, 32'h0);
        // port 3 counted by block 1 from pin 0, divided by two
        wr(8'hc4, 32'h101);
        wr(8'h60, 32'h81);
        tick(10);
        rd(8'h6c, t1);
        repeat (8) begin
            tick(4);
            drv_val <= 32'h1;
            tick(4);
            drv_val <= 32'h0;
        end
        tick(12);
        rd(8'h6c, t2);
        cmp(32'(16'(t2 - t1)), 32'h4);
        wr(8'h60, 32'h0);
        drv_oe <= 32'h0;
        // output on port 1 with strobe, counter step, armed transfer
        wr(8'h20, 32'h13);
        wr(8'h24, 32'h5);
        tick(6);
        cmp(32'(pin_out[3:0]), 32'h5);
        cmp(32'(pin_oe[3:0]), 32'hf);
        cmp(32'(seen_strb), 32'h1);
        rd(8'h2c, t1);
        rd(8'h2c, t2);
        cmp(32'(16'(t2 - t1)), 32'h3);
        t1 = (t2 + 32'd40) & 32'hffff;
        wr(8'h2c, t1);
        wr(8'h24, 32'h9);
        tick(4);
        cmp(32'(pin_out[3:0]), 32'h5);
        tick(60);
        rd(8'h30, q);
        cmp(q, t1);
        cmp(32'(pin_out[3:0]), 32'h9);
        wr(8'h20, 32'h7);
        wr(8'h24, 32'h5);
        tick(6);
        cmp(32'(pin_out[3:0]), 32'h0);
        cmp(32'(pin_oe[3:0]), 32'ha);
        // narrower port wins shared pins, link takes its pins
        wr(8'h20, 32'h3);
        wr(8'h24, 32'h3);
        wr(8'h40, 32'h3);
        wr(8'h44, 32'ha5);
        wr(8'h80, 32'h3);
        wr(8'h84, 32'hffff_ffff);
        tick(6);
        cmp(32'(pin_out[7:0]), 32'ha3);
        cmp(32'(pin_out[31:8]), 32'hff_ffff);
        wr(8'he0, 32'h1);
        tick(6);
        cmp(32'(pin_oe[31:24]), 32'h0);
        cmp(32'(pin_oe[23:8]), 32'hffff);
        end_sim();
    end

    initial begin
        tick(20000);
        err_count++;
        $display("mismatch at %0t: timeout", $time);
        end_sim();
    end
endmodule // timed_io_port_clock_blocks_bench
